// ### hw/light_conv_core.sv
// dual channel light conversion core with apb registers and threshold interrupt
`timescale 1ns/1ps
`default_nettype none

module light_conv_core #(
  parameter int unsigned TINT_SHORT_CYC = light_pkg::TINT_SHORT_CYC,
  parameter int unsigned TINT_MID_CYC   = light_pkg::TINT_MID_CYC,
  parameter int unsigned TINT_LONG_CYC  = light_pkg::TINT_LONG_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  broadband_rate,
  input  wire logic [7:0]  infrared_rate,
  input  wire logic        addr_sel_pu,
  input  wire logic        addr_sel_pd,
  output logic             irq,
  output logic             int_pin_o,
  output logic             int_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  light_pkg::ctrl_t       ctrl_r;
  light_pkg::conv_state_t state_r;
  light_pkg::cnt_t        cnt_r;
  light_pkg::cnt_t        cnt_load;
  light_pkg::data_t       acc_r [2];
  light_pkg::data_t       res_r [2];
  light_pkg::data_t       thr_lo_r;
  light_pkg::data_t       thr_hi_r;
  logic [7:0]             rate [2];
  logic [light_pkg::ST_W-1:0] status_r;
  logic [light_pkg::ST_W-1:0] status_nxt;
  logic [light_pkg::ST_W-1:0] st_set;
  logic [light_pkg::ST_W-1:0] st_clr;
  logic [light_pkg::ST_W-1:0] mask_r;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   irq_r;
  logic                   int_pin_o_r;
  logic                   int_pin_oe_n_r;
  logic [3:0]             pers_cnt_r;
  logic [3:0]             pers_inc;
  logic [3:0]             pers_eff;
  logic                   out_win;
  logic                   thr_set;
  logic                   thr_clr;
  logic                   thr_flag_r;
  logic                   thr_nxt;
  logic                   strap_done_r;
  logic [6:0]             slave_addr_r;
  logic [9:0]             max_rate;
  logic                   setup;
  logic                   acc_ph;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   ara_rd;
  logic                   clr_wr;
  logic [31:0]            rd_val;
  logic                   hit;
  logic                   loading;

  assign rate[0] = broadband_rate;
  assign rate[1] = infrared_rate;

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign irq          = irq_r;
  assign int_pin_o    = int_pin_o_r;
  assign int_pin_oe_n = int_pin_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign setup  = psel && !penable;
  assign acc_ph = psel && penable && pready_r;
  assign wr_acc = acc_ph && pwrite;
  assign rd_acc = acc_ph && !pwrite;
  assign ara_rd = rd_acc && (paddr == light_pkg::OFF_ARA);
  assign clr_wr = wr_acc && (paddr == light_pkg::OFF_CLEAR) &&
                  pwdata[light_pkg::CLEAR_BIT];

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == light_pkg::OFF_CTRL) begin
      rd_val = 32'(ctrl_r);
    end else if (paddr == light_pkg::OFF_STATUS) begin
      rd_val = 32'(status_r);
    end else if (paddr == light_pkg::OFF_MASK) begin
      rd_val = 32'(mask_r);
    end else if (paddr == light_pkg::OFF_THR_LO) begin
      rd_val = 32'(thr_lo_r);
    end else if (paddr == light_pkg::OFF_THR_HI) begin
      rd_val = 32'(thr_hi_r);
    end else if (paddr == light_pkg::OFF_DATA0) begin
      rd_val = 32'(res_r[0]);
    end else if (paddr == light_pkg::OFF_DATA1) begin
      rd_val = 32'(res_r[1]);
    end else if (paddr == light_pkg::OFF_DBOTH) begin
      // one word holds a coherent pair of results
      rd_val = {res_r[1], res_r[0]};
    end else if (paddr == light_pkg::OFF_CLEAR) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == light_pkg::OFF_ARA) begin
      rd_val = 32'(slave_addr_r);
    end else if (paddr == light_pkg::OFF_INFO) begin
      rd_val = (32'(max_rate) << light_pkg::INFO_RATE_LSB)
             | (32'(thr_flag_r) << light_pkg::INFO_PIN_BIT)
             | (32'(state_r == light_pkg::ST_INTEG) << light_pkg::INFO_CONV_BIT)
             | 32'(slave_addr_r);
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      pready_r  <= setup;
      pslverr_r <= setup && !hit;
      prdata_r  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= light_pkg::CTRL_RST;
    end else if (ce && wr_acc && paddr == light_pkg::OFF_CTRL) begin
      ctrl_r <= light_pkg::ctrl_t'(pwdata[light_pkg::CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_lo_r <= light_pkg::THR_LO_RST;
      thr_hi_r <= light_pkg::THR_HI_RST;
    end else if (ce && wr_acc) begin
      if (paddr == light_pkg::OFF_THR_LO) begin
        thr_lo_r <= pwdata[15:0];
      end else if (paddr == light_pkg::OFF_THR_HI) begin
        thr_hi_r <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= light_pkg::MASK_RST;
    end else if (ce && wr_acc && paddr == light_pkg::OFF_MASK) begin
      mask_r <= pwdata[light_pkg::ST_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address strap, caught once after reset release

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_r <= 1'b0;
      slave_addr_r <= 7'h00;
    end else if (ce && !strap_done_r) begin
      strap_done_r <= 1'b1;
      // pulls disagree only while the pin floats
      if (addr_sel_pu && addr_sel_pd) begin
        slave_addr_r <= light_pkg::SADDR_HIGH;
      end else if (!addr_sel_pu && !addr_sel_pd) begin
        slave_addr_r <= light_pkg::SADDR_LOW;
      end else begin
        slave_addr_r <= light_pkg::SADDR_FLOAT;
      end
    end
  end

  // alert variant is the slower smbus flavour
  assign max_rate = ctrl_r.alert_mode ? light_pkg::RATE_SMBUS_KHZ
                                      : light_pkg::RATE_I2C_KHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  always_comb begin
    case (ctrl_r.integ_sel)
      2'h0:    cnt_load = light_pkg::cnt_t'(TINT_SHORT_CYC - 1);
      2'h1:    cnt_load = light_pkg::cnt_t'(TINT_MID_CYC - 1);
      default: cnt_load = light_pkg::cnt_t'(TINT_LONG_CYC - 1);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= light_pkg::ST_OFF;
      cnt_r   <= '0;
    end else if (ce) begin
      case (state_r)
        light_pkg::ST_OFF: begin
          if (ctrl_r.power) begin
            state_r <= light_pkg::ST_INTEG;
            cnt_r   <= cnt_load;
          end
        end
        light_pkg::ST_INTEG: begin
          if (!ctrl_r.power) begin
            state_r <= light_pkg::ST_OFF;
          end else if (cnt_r == '0) begin
            state_r <= light_pkg::ST_LOAD;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        light_pkg::ST_LOAD: begin
          if (!ctrl_r.power) begin
            state_r <= light_pkg::ST_OFF;
          end else begin
            state_r <= light_pkg::ST_INTEG;
            cnt_r   <= cnt_load;
          end
        end
        default: begin
          state_r <= light_pkg::ST_OFF;
        end
      endcase
    end
  end

  assign loading = (state_r == light_pkg::ST_LOAD);

  // saturating add; gain scales the photocurrent sample
  function automatic light_pkg::data_t sat_add(
    input light_pkg::data_t a,
    input logic [7:0]       r,
    input logic             g
  );
    logic [16:0] s;
    logic [16:0] inc;
    inc = g ? (17'(r) << light_pkg::GAIN_SHIFT) : 17'(r);
    s   = {1'b0, a} + inc;
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction

  // working integrators and result buffers per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_r[ch] <= 16'h0000;
      end else if (ce) begin
        if (state_r == light_pkg::ST_INTEG) begin
          acc_r[ch] <= sat_add(acc_r[ch], rate[ch], ctrl_r.gain_hi);
        end else begin
          acc_r[ch] <= 16'h0000;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        res_r[ch] <= 16'h0000;
      end else if (ce && loading) begin
        res_r[ch] <= acc_r[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // threshold window and persistence

  assign out_win  = (acc_r[0] > thr_hi_r) || (acc_r[0] < thr_lo_r);
  assign pers_inc = (pers_cnt_r == 4'hF) ? 4'hF : pers_cnt_r + 4'h1;
  assign pers_eff = (ctrl_r.persist == 4'h0) ? 4'h1 : ctrl_r.persist;
  assign thr_set  = loading && ctrl_r.int_en && out_win &&
                    (pers_inc >= pers_eff);

  // level mode clears by register write, alert mode by response read
  assign thr_clr  = ctrl_r.alert_mode ? ara_rd : clr_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers_cnt_r <= 4'h0;
    end else if (ce) begin
      if (thr_clr) begin
        pers_cnt_r <= 4'h0;
      end else if (loading) begin
        pers_cnt_r <= out_win ? pers_inc : 4'h0;
      end
    end
  end

  // a new event wins over a clear in the same cycle
  assign thr_nxt = thr_set || (thr_flag_r && !thr_clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_flag_r     <= 1'b0;
      int_pin_o_r    <= 1'b0;
      int_pin_oe_n_r <= 1'b1;
    end else if (ce) begin
      thr_flag_r     <= thr_nxt;
      int_pin_o_r    <= 1'b0;
      int_pin_oe_n_r <= !thr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status, read to clear, masked interrupt

  always_comb begin
    st_set = '0;
    st_set[light_pkg::ST_DONE] = loading;
    st_set[light_pkg::ST_THR]  = thr_set;
    // only bits already shown to the reader are cleared
    st_clr = (rd_acc && paddr == light_pkg::OFF_STATUS) ?
             prdata_r[light_pkg::ST_W-1:0] : '0;
    status_nxt = (status_r & ~st_clr) | st_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      irq_r    <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  chk_load_chan: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && loading) |=> (res_r[0] == $past(acc_r[0]) && res_r[1] == $past(acc_r[1])))
    else $error("results not loaded per channel");

  chk_sim_start: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && loading && ctrl_r.power)
      |=> (acc_r[0] == 16'h0000 && acc_r[1] == 16'h0000))
    else $error("channels do not restart together");

  chk_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && loading && ctrl_r.power) |=> (state_r == light_pkg::ST_INTEG && cnt_r == $past(cnt_load)))
    else $error("no automatic restart");

  chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !loading |=> ($stable(res_r[0]) && $stable(res_r[1])))
    else $error("result changed outside load");

  chk_integ_count: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == light_pkg::ST_OFF && ctrl_r.power && ctrl_r.integ_sel == 2'h0)
      |=> (cnt_r == light_pkg::cnt_t'(TINT_SHORT_CYC - 1)))
    else $error("wrong integration count");

  chk_power_off: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !ctrl_r.power) |=> (state_r == light_pkg::ST_OFF))
    else $error("conversion runs while powered down");

  chk_window_fire: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && loading && ctrl_r.int_en && acc_r[0] > thr_hi_r && pers_inc >= pers_eff)
      |=> (thr_flag_r && !int_pin_oe_n_r))
    else $error("out of window value did not interrupt");

  chk_persist_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !thr_flag_r && pers_inc < pers_eff) |=> !thr_flag_r)
    else $error("interrupt before persistence reached");

  chk_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (thr_flag_r && !(ce && thr_clr)) |=> thr_flag_r)
    else $error("interrupt dropped without clear");

  chk_alert_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ctrl_r.alert_mode && ara_rd && !thr_set) |=> !thr_flag_r)
    else $error("alert response did not release");

  chk_od_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (!int_pin_o_r && (int_pin_oe_n_r == !thr_flag_r)))
    else $error("open drain pin misdriven");

  chk_clear_rearm: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && thr_clr && !thr_set) |=> (int_pin_oe_n_r && pers_cnt_r == 4'h0))
    else $error("clear did not release and rearm");

  chk_thr_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && wr_acc) |=> ($stable(thr_lo_r) && $stable(thr_hi_r)))
    else $error("threshold changed without write");

  chk_addr_strap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_r) |-> (slave_addr_r == (($past(addr_sel_pu) && $past(addr_sel_pd)) ?
      light_pkg::SADDR_HIGH : (($past(addr_sel_pu) || $past(addr_sel_pd)) ?
      light_pkg::SADDR_FLOAT : light_pkg::SADDR_LOW))))
    else $error("wrong slave address decode");

endmodule

`default_nettype wire

// ### common/light_pkg.sv
// constants and types shared by the dual channel light conversion core
// Summary of operation
// - both channels integrate together every cycle
// - each channel loads its own result register
// - results double buffered, never read half updated
// - next integration starts by itself after load
// - results are unsigned 16 bit values
// - interrupt when value leaves threshold window
// - host sets both thresholds, device holds them
// - interrupt only after configured persistence count
// - level mode holds interrupt until host clears
// - alert mode released by alert response read
// - interrupt pin is open drain, pulls low
// - three state select pin picks slave address
// - smbus 100kHz, i2c 400kHz, host no faster
// - programmable gain and integration time
// - power down stops conversions, active runs them
`default_nettype none
package light_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_THR_LO = 8'h0C;
  localparam logic [7:0] OFF_THR_HI = 8'h10;
  localparam logic [7:0] OFF_DATA0  = 8'h14;
  localparam logic [7:0] OFF_DATA1  = 8'h18;
  localparam logic [7:0] OFF_DBOTH  = 8'h1C;
  localparam logic [7:0] OFF_CLEAR  = 8'h20;
  localparam logic [7:0] OFF_ARA    = 8'h24;
  localparam logic [7:0] OFF_INFO   = 8'h28;

  typedef logic [15:0] data_t;
  localparam int CNT_W = 26;
  typedef logic [CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic [3:0] persist;
    logic       alert_mode;
    logic       int_en;
    logic       gain_hi;
    logic [1:0] integ_sel;
    logic       power;
  } ctrl_t;

  localparam int    CTRL_W   = $bits(ctrl_t);
  localparam ctrl_t CTRL_RST = 10'h000;
  localparam data_t THR_LO_RST = 16'h0000;
  localparam data_t THR_HI_RST = 16'hFFFF;
  localparam logic [1:0] MASK_RST = 2'h0;

  // status and mask layout
  localparam int ST_DONE = 0;
  localparam int ST_THR  = 1;
  localparam int ST_W    = 2;

  // info register layout
  localparam int INFO_CONV_BIT = 7;
  localparam int INFO_PIN_BIT  = 8;
  localparam int INFO_RATE_LSB = 16;
  localparam int CLEAR_BIT     = 0;

  localparam int GAIN_SHIFT = 4;

  // integration times, then cycles at the core clock
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned TINT_SHORT_US  = 13700;
  localparam int unsigned TINT_MID_US    = 101000;
  localparam int unsigned TINT_LONG_US   = 402000;
  localparam int unsigned TINT_SHORT_CYC = TINT_SHORT_US * CLK_MHZ;
  localparam int unsigned TINT_MID_CYC   = TINT_MID_US * CLK_MHZ;
  localparam int unsigned TINT_LONG_CYC  = TINT_LONG_US * CLK_MHZ;

  localparam logic [9:0] RATE_SMBUS_KHZ = 10'd100;
  localparam logic [9:0] RATE_I2C_KHZ   = 10'd400;

  // slave addresses per select pin state, values arbitrary
  localparam logic [6:0] SADDR_LOW   = 7'h10;
  localparam logic [6:0] SADDR_FLOAT = 7'h11;
  localparam logic [6:0] SADDR_HIGH  = 7'h12;

  typedef enum logic [1:0] {ST_OFF, ST_INTEG, ST_LOAD} conv_state_t;

endpackage

`default_nettype wire

// ### verif/light_source_model.sv
// light source and board model around the conversion core
`timescale 1ns/1ps
`default_nettype none

module light_source_model (
  input  wire logic       pclk,
  input  wire logic [7:0] bb_level,
  input  wire logic [7:0] ir_level,
  input  wire logic [1:0] strap,
  input  wire logic       int_pin_o,
  input  wire logic       int_pin_oe_n,
  output logic      [7:0] broadband_rate,
  output logic      [7:0] infrared_rate,
  output logic            addr_sel_pu,
  output logic            addr_sel_pd,
  output logic            int_line
);
  ////////////////////////////////////////
  // both photodiodes lit together, one sample per cycle
  always @(posedge pclk) begin
    broadband_rate <= bb_level;
    infrared_rate  <= ir_level;
  end
  // strap 0 low, 1 high, 2 left floating
  assign addr_sel_pu = (strap != 2'h0);
  assign addr_sel_pd = (strap == 2'h1);
  // board pull-up holds the line once released
  assign int_line = int_pin_oe_n ? 1'b1 : int_pin_o;
endmodule

`default_nettype wire

// ### verif/dual_channel_light_conversion_irq_tb_top.sv
// self-checking bench for the dual channel light conversion core
`timescale 1ns/1ps
`default_nettype none

module dual_channel_light_conversion_irq_tb_top;
  // short integration counts keep the run brief
  localparam int T_S = 8;
  localparam int T_M = 16;
  localparam int T_L = 32;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  bb_lv = 8'h00;
  logic [7:0]  ir_lv = 8'h00;
  logic [1:0]  strap = 2'h0;
  logic [7:0]  bb_rate;
  logic [7:0]  ir_rate;
  logic        sel_pu;
  logic        sel_pd;
  logic        irq;
  logic        pin_o;
  logic        pin_oe_n;
  logic        int_line;
  logic [31:0] rd;
  logic        er;
  logic        g_v;
  logic [1:0]  is_v;
  logic [15:0] eb;
  logic [15:0] ei;
  int          num_errors = 0;
  int          comparisons = 0;

  light_conv_core #(.TINT_SHORT_CYC(T_S), .TINT_MID_CYC(T_M), .TINT_LONG_CYC(T_L)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .broadband_rate(bb_rate), .infrared_rate(ir_rate),
    .addr_sel_pu(sel_pu), .addr_sel_pd(sel_pd), .irq(irq), .int_pin_o(pin_o),
    .int_pin_oe_n(pin_oe_n));

  light_source_model src_u (
    .pclk(pclk), .bb_level(bb_lv), .ir_level(ir_lv), .strap(strap), .int_pin_o(pin_o),
    .int_pin_oe_n(pin_oe_n), .broadband_rate(bb_rate), .infrared_rate(ir_rate),
    .addr_sel_pu(sel_pu), .addr_sel_pd(sel_pd), .int_line(int_line));

  initial begin
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; waits for pready, samples the answer at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst(input logic [1:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    strap   <= s;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // polls the sticky done flag; the read also clears it
  task automatic wait_done();
    do begin
      apb(1'b0, light_pkg::OFF_STATUS, 32'h0);
    end while (rd[0] !== 1'b1);
  endtask

  function automatic logic [15:0] exp_res(logic [7:0] r, logic g, logic [1:0] is);
    int v;
    v = r * (g ? 16 : 1) * ((is == 2'h0) ? T_S : (is == 2'h1) ? T_M : T_L);
    return (v > 65535) ? 16'hFFFF : v[15:0];
  endfunction

  function automatic logic [31:0] ctrl(logic [3:0] p, logic al, logic ie, logic g,
                                       logic [1:0] is, logic pw);
    return {22'h0, p, al, ie, g, is, pw};
  endfunction

  ////////////////////////////////////////
  initial begin
    void'($urandom(87));
    fork
      begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        stop_test();
      end
    join_none
    for (int s = 0; s < 3; s++) begin
      rst(s[1:0]);
      apb(1'b0, light_pkg::OFF_ARA, 32'h0);
      check(rd, {25'h0, (s == 0) ? light_pkg::SADDR_LOW : (s == 1) ?
                 light_pkg::SADDR_HIGH : light_pkg::SADDR_FLOAT});
    end
    apb(1'b1, light_pkg::OFF_STATUS, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, (i == 4) ? 32'hFFFF : 32'h0);
    end
    apb(1'b0, 8'h2C, 32'h0);
    check(32'(er), 32'h1);
    // random rates; first pass saturates, second has a dark channel
    for (int i = 0; i < 5; i++) begin
      g_v  = (i == 0) | 1'($urandom());
      is_v = (i == 0) ? 2'h3 : 2'($urandom());
      bb_lv <= (i == 0) ? 8'hFF : 8'($urandom());
      ir_lv <= (i == 1) ? 8'h00 : 8'($urandom());
      apb(1'b1, light_pkg::OFF_MASK, 32'(i % 2));
      apb(1'b1, light_pkg::OFF_CTRL, ctrl(4'h0, 1'b0, 1'b0, g_v, is_v, 1'b1));
      // frozen core must not finish a conversion
      ce <= 1'b0;
      repeat (T_L + 6) @(posedge pclk);
      check(32'(irq), 32'h0);
      ce <= 1'b1;
      repeat (T_L + 6) @(posedge pclk);
      check(32'(irq), 32'(i % 2));
      apb(1'b1, light_pkg::OFF_CTRL, ctrl(4'h0, 1'b0, 1'b0, g_v, is_v, 1'b0));
      repeat (T_L + 2) @(posedge pclk);
      eb = exp_res(bb_lv, g_v, is_v);
      ei = exp_res(ir_lv, g_v, is_v);
      apb(1'b0, light_pkg::OFF_STATUS, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, light_pkg::OFF_DBOTH, 32'h0);
      check(rd, {ei, eb});
      apb(1'b0, light_pkg::OFF_DATA0, 32'h0);
      check(rd, {16'h0, eb});
      apb(1'b0, light_pkg::OFF_DATA1, 32'h0);
      check(rd, {16'h0, ei});
      check(32'(irq), 32'h0);
      apb(1'b0, light_pkg::OFF_STATUS, 32'h0);
      check(rd, 32'h0);
    end
    // level mode above the window, then alert mode below it
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, light_pkg::OFF_CTRL, 32'h0);
      apb(1'b1, light_pkg::OFF_CLEAR, 32'h1);
      bb_lv <= (m == 1) ? 8'h01 : 8'h20;
      apb(1'b1, light_pkg::OFF_THR_LO, 32'h100);
      apb(1'b1, light_pkg::OFF_THR_HI, 32'h800);
      apb(1'b0, light_pkg::OFF_THR_HI, 32'h0);
      check(rd, 32'h800);
      apb(1'b1, light_pkg::OFF_CTRL, ctrl(4'(2 + m), m[0], 1'b1, ~m[0], 2'h0, 1'b1));
      apb(1'b0, light_pkg::OFF_INFO, 32'h0);
      check({22'h0, rd[25:16]}, {22'h0, m[0] ? light_pkg::RATE_SMBUS_KHZ :
                                 light_pkg::RATE_I2C_KHZ});
      for (int k = 1; k <= 2 + m; k++) begin
        wait_done();
        check(32'({int_line, rd[1]}), 32'({k < 2 + m, k == 2 + m}));
      end
      // the other mode's clear must leave the pin asserted
      apb(m[0], (m == 1) ? light_pkg::OFF_CLEAR : light_pkg::OFF_ARA, 32'h1);
      // pin updates at the access edge, look one cycle later
      @(posedge pclk);
      check(32'(int_line), 32'h0);
      wait_done();
      apb(~m[0], (m == 1) ? light_pkg::OFF_ARA : light_pkg::OFF_CLEAR, 32'h1);
      @(posedge pclk);
      check(32'(int_line), 32'h1);
      wait_done();
      check(32'(int_line), 32'h1);
    end
    stop_test();
  end
endmodule

`default_nettype wire
